// ==== include/pwm7_pkg.sv ====
package pwm7_pkg;
	// Register byte offsets on the AHB-Lite port.
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] DUTY_OFS = 8'h04;
	localparam logic [7:0] PAIR_OFS = 8'h08;
	localparam logic [7:0] SYS_OFS = 8'h0C;
	localparam logic [7:0] STAT_OFS = 8'h10;
	// Field positions in the mode register.
	localparam int CKSEL_LSB = 0;
	localparam int INIT_BIT = 3;
	localparam int DBUF_BIT = 4;
	// Field positions in the pair control register.
	localparam int RUN_BIT = 0;
	localparam int AND_BIT = 1;
	// Field positions in the system control register.
	localparam int SLOWPRE_BIT = 0;
	localparam int SLOWMODE_BIT = 1;
	// Duty register: duty in bits 7:1, extra-pulse select in bit 0.
	localparam int XPULSE_BIT = 0;
	localparam int DUTY_LSB = 1;
	// Status register layout.
	localparam int ST_OUT_BIT = 0;
	localparam int ST_RUN_BIT = 1;
	localparam int ST_EVEN_BIT = 2;
	localparam int ST_CNT_LSB = 8;
	// Values after reset.
	localparam logic [7:0] DUTY_RST = 8'hFF;
	localparam logic [4:0] MODE_RST = 5'h00;
	localparam logic [1:0] PAIR_RST = 2'h0;
	localparam logic [1:0] SYS_RST = 2'h0;
	// Counter period and last count before overflow.
	localparam int PERIOD = 128;
	localparam logic [6:0] CNT_LAST = 7'(PERIOD - 1);
	// Divider exponents of the gear clock for codes 0 to 7.
	localparam logic [3:0] GEAR_LOG0 = 4'hB;
	localparam logic [3:0] GEAR_LOG1 = 4'hA;
	localparam logic [3:0] GEAR_LOG2 = 4'h8;
	localparam logic [3:0] GEAR_LOG3 = 4'h6;
	localparam logic [3:0] GEAR_LOG4 = 4'h4;
	localparam logic [3:0] GEAR_LOG5 = 4'h2;
	localparam logic [3:0] GEAR_LOG6 = 4'h1;
	localparam logic [3:0] GEAR_LOG7 = 4'h0;
	// Divider exponents of the low-frequency clock.
	localparam logic [2:0] LF_LOG0 = 3'h4;
	localparam logic [2:0] LF_LOG1 = 3'h3;
	localparam logic [2:0] LF_LOG7 = 3'h2;
	localparam int GEAR_W = 11;
	localparam int LF_W = 4;
endpackage

// ==== verilog/pwm7_channel.sv ====
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module pwm7_channel (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic LOW_FREQUENCY_CLOCK,
	input wire logic SIBLING_OUT,
	input wire logic PIN_FUNCTION,
	output logic PULSE_OUTPUT_PIN,
	output logic PULSE_OUTPUT_OE,
	output logic CHANNEL_OUT,
	output logic PERIOD_INTERRUPT
);
	import pwm7_pkg::*;

	// Bus data phase state.
	logic wr_pend_q;
	logic [7:0] addr_q;
	// Software-visible control.
	logic [4:0] mode_q;
	logic [1:0] pair_q;
	logic [1:0] sys_q;
	logic [7:0] duty_act_q;
	logic [7:0] duty_buf_q;
	// Counting state.
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic tog_q;
	logic tog_d;
	logic even_q;
	logic even_d;
	logic irq_q;
	logic irq_d;
	logic pin_q;
	// Prescalers and the synchronised low-frequency clock.
	logic [GEAR_W-1:0] gear_q;
	logic [LF_W-1:0] lf_cnt_q;
	logic lf_s1_q;
	logic lf_s2_q;
	logic lf_prev_q;

	// Address phase decode; the slave never stalls.
	wire addr_ok = HSEL && HREADY && HTRANS[1];
	wire wr_mode = wr_pend_q && (addr_q == MODE_OFS);
	wire wr_duty = wr_pend_q && (addr_q == DUTY_OFS);
	wire wr_pair = wr_pend_q && (addr_q == PAIR_OFS);
	wire wr_sys = wr_pend_q && (addr_q == SYS_OFS);
	wire [7:0] wdat = HWDATA[7:0];

	// Named control fields.
	wire running = pair_q[RUN_BIT];
	wire and_sel = pair_q[AND_BIT];
	wire init_lvl = mode_q[INIT_BIT];
	wire dbuf_en = mode_q[DBUF_BIT];
	wire [2:0] cksel = mode_q[CKSEL_LSB +: 3];
	wire slow_pre = sys_q[SLOWPRE_BIT];
	wire slow_mode = sys_q[SLOWMODE_BIT];
	wire [6:0] duty = duty_act_q[DUTY_LSB +: 7];
	wire xpulse = duty_act_q[XPULSE_BIT];

	// Gear divider exponent for the selected code.
	logic [3:0] gear_log;
	always_comb begin
		unique case (cksel)
			3'h0: gear_log = GEAR_LOG0;
			3'h1: gear_log = GEAR_LOG1;
			3'h2: gear_log = GEAR_LOG2;
			3'h3: gear_log = GEAR_LOG3;
			3'h4: gear_log = GEAR_LOG4;
			3'h5: gear_log = GEAR_LOG5;
			3'h6: gear_log = GEAR_LOG6;
			3'h7: gear_log = GEAR_LOG7;
		endcase
	end

	// A divide by 2^k ticks when the low k prescaler bits are all one.
	// Exponent zero yields a mask of zero, so it ticks every cycle.
	wire [GEAR_W-1:0] gear_mask = GEAR_W'((12'h001 << gear_log) - 12'h001);
	wire gear_tick = &(gear_q | ~gear_mask);

	// Low-frequency clock rising edge, seen only after two flops.
	wire lf_edge = lf_s2_q && !lf_prev_q;
	logic [2:0] lf_log;
	logic lf_avail;
	always_comb begin
		lf_log = LF_LOG7;
		lf_avail = 1'b0;
		unique case (cksel)
			3'h0: begin
				lf_log = LF_LOG0;
				lf_avail = 1'b1;
			end
			3'h1: begin
				lf_log = LF_LOG1;
				lf_avail = 1'b1;
			end
			3'h7: begin
				lf_log = LF_LOG7;
				lf_avail = slow_mode;
			end
			default: begin
				lf_log = LF_LOG7;
				lf_avail = 1'b0;
			end
		endcase
	end
	wire [LF_W-1:0] lf_mask = LF_W'((5'h01 << lf_log) - 5'h01);
	wire lf_tick = lf_avail && lf_edge && (&(lf_cnt_q | ~lf_mask));

	// Slow or sleep modes count only on the low-frequency ticks; in
	// normal modes codes 000 and 001 move there under slow prescale.
	wire use_lf = slow_mode || (slow_pre && (cksel <= 3'h1));
	wire src_tick = use_lf ? lf_tick : gear_tick;

	// Compare target: duty, or duty plus one in every second period.
	wire add_one = xpulse && even_q;
	wire [7:0] target = {1'b0, duty} + {7'h00, add_one};
	wire match = ({1'b0, cnt_q} == target);
	wire ovf = src_tick && (cnt_q == CNT_LAST);
	// A stop written in this cycle clears the count at the same edge as
	// the run bit, so a read right after the stop never sees stale state.
	wire stop_now = wr_pair && !wdat[RUN_BIT];
	// The tick that brings the count onto the target toggles at once, so
	// the level before the change lasts exactly target source counts.
	wire step_hit = src_tick && ({1'b0, cnt_q + 7'h01} == target);
	// A zero target in the coming period matches as the counter wraps.
	wire wrap_hit = (duty == 7'h00) && !(xpulse && !even_q);

	// Counter, toggle state and period parity.
	// Matching is checked every clock, not only on ticks, so a duty
	// written equal to the count with buffering off matches at once, off the tick grid.
	always_comb begin
		cnt_d = cnt_q;
		tog_d = tog_q;
		even_d = even_q;
		irq_d = 1'b0;
		if (!running || stop_now) begin
			cnt_d = 7'h00;
			tog_d = 1'b0;
			even_d = 1'b0;
		end else if (ovf) begin
			cnt_d = 7'h00;
			tog_d = wrap_hit;
			even_d = !even_q;
			irq_d = even_q;
		end else begin
			if (src_tick) begin
				cnt_d = cnt_q + 7'h01;
			end
			// Only one toggle per period; a duty below the count waits.
			if (!tog_q && (match || step_hit)) begin
				tog_d = 1'b1;
			end
		end
	end

	// Output level: stopped or cleared toggle shows the initial level.
	wire own_out = init_lvl ^ tog_q;
	wire pin_d = and_sel ? (own_out & SIBLING_OUT) : own_out;

	// Buffer transfer happens at the even overflow that raises the event, unless a duty write falls in that cycle.
	wire buf_load = running && dbuf_en && ovf && even_q;

	// Bus address phase capture.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (HREADY) begin
			wr_pend_q <= addr_ok && HWRITE;
			addr_q <= addr_ok ? HADDR[7:0] : 8'h00;
		end
	end

	// Mode writes are ignored while running, so settings stay coherent.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_q <= MODE_RST;
			pair_q <= PAIR_RST;
			sys_q <= SYS_RST;
		end else begin
			if (wr_mode && !running) begin
				mode_q <= wdat[4:0];
			end
			if (wr_pair) begin
				pair_q <= wdat[1:0];
			end
			if (wr_sys) begin
				sys_q <= wdat[1:0];
			end
		end
	end

	// Duty registers: the buffer always holds the last written value.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			duty_act_q <= DUTY_RST;
			duty_buf_q <= DUTY_RST;
		end else if (wr_duty) begin
			duty_buf_q <= wdat;
			if (!running || !dbuf_en) begin
				duty_act_q <= wdat;
			end
		end else if (buf_load) begin
			duty_act_q <= duty_buf_q;
		end
	end

	// Counting state flops.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_q <= 7'h00;
			tog_q <= 1'b0;
			even_q <= 1'b0;
			irq_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tog_q <= tog_d;
			even_q <= even_d;
			irq_q <= irq_d;
			pin_q <= pin_d;
		end
	end

	// Free-running prescalers; they are not restarted by the run bit.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gear_q <= '0;
			lf_cnt_q <= '0;
		end else begin
			gear_q <= gear_q + GEAR_W'(1);
			if (lf_edge) begin
				lf_cnt_q <= lf_cnt_q + LF_W'(1);
			end
		end
	end

	// Two-flop synchroniser for the asynchronous low-frequency clock.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			lf_s1_q <= 1'b0;
			lf_s2_q <= 1'b0;
			lf_prev_q <= 1'b0;
		end else begin
			lf_s1_q <= LOW_FREQUENCY_CLOCK;
			lf_s2_q <= lf_s1_q;
			lf_prev_q <= lf_s2_q;
		end
	end

	// Read mux over the data phase address; unmapped reads give zero.
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (addr_q)
			MODE_OFS: rdata[4:0] = mode_q;
			DUTY_OFS: rdata[7:0] = duty_buf_q;
			PAIR_OFS: rdata[1:0] = pair_q;
			SYS_OFS: rdata[1:0] = sys_q;
			STAT_OFS: begin
				rdata[ST_OUT_BIT] = own_out;
				rdata[ST_RUN_BIT] = running;
				rdata[ST_EVEN_BIT] = even_q;
				rdata[ST_CNT_LSB +: 7] = cnt_q;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	// Bus answers: zero wait states, always OKAY.
	assign HRDATA = rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// Pin drive follows the port function setting.
	assign PULSE_OUTPUT_PIN = pin_q;
	assign PULSE_OUTPUT_OE = PIN_FUNCTION;
	assign CHANNEL_OUT = own_out;
	assign PERIOD_INTERRUPT = irq_q;
endmodule

// ==== tb/pin_load.sv ====
`timescale 1ns/10ps
// External load on the pulse pin: counts cycles driven high.
module pin_load (
	input wire logic clk,
	input wire logic clr,
	input wire logic pin,
	input wire logic oe,
	output int hi
);
	// A released pin adds nothing, so only driven levels count.
	always_ff @(posedge clk) begin
		hi <= clr ? 0 : hi + int'(pin & oe);
	end
endmodule

// ==== tb/pwm7_assertions.sv ====
`timescale 1ns/10ps
module pwm7_checker import pwm7_pkg::*; (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic SIBLING_OUT,
	input wire logic PIN_FUNCTION,
	input wire logic PULSE_OUTPUT_PIN,
	input wire logic PULSE_OUTPUT_OE,
	input wire logic CHANNEL_OUT,
	input wire logic PERIOD_INTERRUPT
);
	logic rd_q;
	logic [7:0] ad_q;
	wire stat_w = rd_q && ad_q == STAT_OFS;
	// Track which read is in its data phase.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rd_q <= 1'b0;
			ad_q <= 8'h00;
		end else if (HREADY) begin
			rd_q <= HSEL & HTRANS[1] & ~HWRITE;
			ad_q <= HADDR[7:0];
		end
	end
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	bus_okay_a: assert property (HREADYOUT && !HRESP)
		else $error("bus answer not zero-wait okay");
	unmapped_a: assert property (rd_q && ad_q > STAT_OFS |-> HRDATA == 0)
		else $error("unmapped read not zero");
	oe_follow_a: assert property (PULSE_OUTPUT_OE == PIN_FUNCTION)
		else $error("pin enable differs from function select");
	pin_gate_a: assert property (PULSE_OUTPUT_PIN |-> $past(CHANNEL_OUT))
		else $error("pin high without channel level");
	pin_pass_a: assert property ($past(CHANNEL_OUT & SIBLING_OUT) |-> PULSE_OUTPUT_PIN)
		else $error("pin low while both channels high");
	irq_pulse_a: assert property (PERIOD_INTERRUPT |=> !PERIOD_INTERRUPT)
		else $error("period event longer than a cycle");
	irq_gap_a: assert property ($rose(PERIOD_INTERRUPT) |=> !PERIOD_INTERRUPT [*8])
		else $error("period events too close");
	stat_level_a: assert property (stat_w |-> HRDATA[ST_OUT_BIT] == CHANNEL_OUT)
		else $error("status level differs from channel");
	stop_clear_a: assert property (stat_w && !HRDATA[ST_RUN_BIT] |-> HRDATA[14:8] == 0)
		else $error("stopped counter not cleared");
endmodule
bind pwm7_channel pwm7_checker chk_u (.*);

// ==== tb/timer_pwm7_extra_pulse_bench.sv ====
`timescale 1ns/10ps
module timer_pwm7_extra_pulse_bench;
	import pwm7_pkg::*;
	logic CLK = 0, RSTN = 0, HSEL = 0, HWRITE = 0, HREADY;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2;
	logic LOW_FREQUENCY_CLOCK = 0, SIBLING_OUT = 1, PIN_FUNCTION = 1;
	logic HREADYOUT, HRESP, PULSE_OUTPUT_PIN, PULSE_OUTPUT_OE;
	logic CHANNEL_OUT, PERIOD_INTERRUPT, clr = 1;
	int n_errors = 0, checked = 0, n_irq = 0, hi;
	assign HREADY = HREADYOUT;
	pwm7_channel dut_u (.*);
	pin_load load_u (.clk(CLK), .clr(clr), .pin(PULSE_OUTPUT_PIN),
		.oe(PULSE_OUTPUT_OE), .hi(hi));
	// Gear clock, and a slow clock offset so it never meets a gear edge.
	always #25 CLK = ~CLK;
	initial begin
		#10;
		forever #175 LOW_FREQUENCY_CLOCK = ~LOW_FREQUENCY_CLOCK;
	end
	// Count period events seen on the interrupt output.
	always @(posedge CLK) if (PERIOD_INTERRUPT === 1'b1) n_irq++;
	task automatic chk(input string what, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		r = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(s, e, r);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask
	// Whole periods only, so the result does not hang on start phase.
	task automatic meas(input int n, h, q);
		clr <= 1'b1;
		@(posedge CLK);
		#1;
		clr <= 1'b0;
		n_irq = 0;
		wt(n);
		#1;
		chk("high cycles", h, hi);
		chk("events", q, n_irq);
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2_000_000;
		n_errors++;
		end_of_test();
	end
	// Mode values: bits 2:0 clock code, bit 3 initial level, bit 4 buffer.
	initial begin
		wt(8);
		RSTN <= 1'b1;
		wt(1);
		rd(DUTY_OFS, 32'(DUTY_RST), "duty reset");
		rd(MODE_OFS, 32'h0, "mode reset");
		rd(8'h20, 32'h0, "unmapped");
		wr(MODE_OFS, 32'h0F);
		wt(3);
		chk("stopped pin", 1, PULSE_OUTPUT_PIN);
		wr(MODE_OFS, 32'h07);
		wr(DUTY_OFS, 32'h14);
		rd(DUTY_OFS, 32'h14, "duty stopped");
		wr(PAIR_OFS, 32'h1);
		meas(512, 4 * (PERIOD - 10), 2);
		wr(MODE_OFS, 32'h17);
		rd(MODE_OFS, 32'h07, "mode while running");
		wr(DUTY_OFS, 32'h15);
		wt(300);
		meas(512, 4 * (PERIOD - 10) - 2, 2);
		wr(PAIR_OFS, 32'h3);
		SIBLING_OUT <= 1'b0;
		meas(512, 0, 2);
		SIBLING_OUT <= 1'b1;
		meas(512, 4 * (PERIOD - 10) - 2, 2);
		PIN_FUNCTION <= 1'b0;
		meas(256, 0, 1);
		PIN_FUNCTION <= 1'b1;
		wr(PAIR_OFS, 32'h0);
		rd(STAT_OFS, 32'h0, "status stopped");
		wr(DUTY_OFS, 32'hC8);
		wr(PAIR_OFS, 32'h1);
		wt(60);
		wr(DUTY_OFS, 32'h28);
		wt(40);
		chk("below count", 0, CHANNEL_OUT);
		wt(60);
		chk("after wrap", 1, CHANNEL_OUT);
		wr(PAIR_OFS, 32'h0);
		wr(MODE_OFS, 32'h17);
		wr(DUTY_OFS, 32'h14);
		wr(PAIR_OFS, 32'h1);
		wr(DUTY_OFS, 32'hC8);
		rd(DUTY_OFS, 32'hC8, "buffered read");
		wt(40);
		chk("old duty", 1, CHANNEL_OUT);
		wt(128);
		chk("odd overflow", 1, CHANNEL_OUT);
		wt(128);
		chk("even overflow", 0, CHANNEL_OUT);
		wr(PAIR_OFS, 32'h0);
		wr(MODE_OFS, 32'h06);
		wr(PAIR_OFS, 32'h1);
		meas(512, 4 * (PERIOD - 100), 1);
		wr(PAIR_OFS, 32'h0);
		wr(SYS_OFS, 32'h2);
		wr(MODE_OFS, 32'h02);
		wr(PAIR_OFS, 32'h1);
		wt(100);
		rd(STAT_OFS, 32'h2, "no slow tick");
		wr(PAIR_OFS, 32'h0);
		wr(MODE_OFS, 32'h07);
		wr(PAIR_OFS, 32'h1);
		meas(7168, 56 * (PERIOD - 100), 1);
		end_of_test();
	end
endmodule
